// *** pcm_pkg.sv ***
// Constants shared by the serial PCM frame port.
package pcm_pkg;

  // ---------------------------------------------------------------------------
  // Frame and word layout
  // ---------------------------------------------------------------------------
  localparam int FRAME_CLKS = 256;
  localparam int LIN_BITS = 13;
  localparam int CMP_BITS = 8;
  localparam int GAIN_BITS = 3;
  localparam int RX_LIN_SLOTS = LIN_BITS + GAIN_BITS;
  localparam int SLOT_W = 9;
  localparam logic [SLOT_W-1:0] SLOT_FIRST = 9'h001;
  localparam logic [SLOT_W-1:0] SLOT_FRAME = 9'h100;
  localparam logic [SLOT_W-1:0] SLOT_MAX = 9'h1ff;
  localparam logic [SLOT_W-1:0] SLOT_LIN_LAST = 9'h00d;
  localparam logic [SLOT_W-1:0] SLOT_CMP_LAST = 9'h008;
  localparam logic [SLOT_W-1:0] SLOT_RX_LIN_LAST = 9'h010;

  // ---------------------------------------------------------------------------
  // Receive gain
  // ---------------------------------------------------------------------------
  localparam logic signed [5:0] GAIN_TOP_DB = 6'sh03;
  localparam logic signed [5:0] GAIN_STEP_DB = 6'sh03;
  localparam logic signed [5:0] GAIN_FIXED_DB = 6'sh00;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int PD_TIMEOUT_NS = 2000;
  localparam int PD_TIMEOUT_CLKS = PD_TIMEOUT_NS / CLK_NS;
  localparam int IDLE_W = 8;

endpackage

// *** pcm_serial_frame_port.sv ***
// Serial PCM frame port: sync detection, receive capture and transmit shifting.
module pcm_serial_frame_port
  import pcm_pkg::*;
#(
  parameter int TX_W = LIN_BITS,
  parameter int RX_W = RX_LIN_SLOTS
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic mclk_in,
  input wire logic frame_sync_in,
  input wire logic serial_rx_data_in,
  input wire logic linear_select_in,
  input wire logic [TX_W-1:0] tx_sample_in,
  output logic tx_load_out,
  output logic serial_tx_data_out,
  output logic serial_tx_data_oe_b_out,
  output logic [LIN_BITS-1:0] rx_sample_out,
  output logic [GAIN_BITS-1:0] rx_gain_code_out,
  output logic signed [5:0] rx_gain_db_out,
  output logic rx_valid_out,
  output logic frame_error_out,
  output logic power_down_out
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers and master clock edges
  // ---------------------------------------------------------------------------
  logic [1:0] mclk_meta_q, sync_meta_q, rxd_meta_q, lin_meta_q;
  logic mclk_s, sync_s, rxd_s, lin_s, mclk_prev_q, rise_w, fall_w;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mclk_meta_q <= 2'h0;
      sync_meta_q <= 2'h0;
      rxd_meta_q <= 2'h0;
      lin_meta_q <= 2'h0;
      mclk_prev_q <= 1'b0;
    end else begin
      mclk_meta_q <= {mclk_meta_q[0], mclk_in};
      sync_meta_q <= {sync_meta_q[0], frame_sync_in};
      rxd_meta_q <= {rxd_meta_q[0], serial_rx_data_in};
      lin_meta_q <= {lin_meta_q[0], linear_select_in};
      mclk_prev_q <= mclk_s;
    end
  end

  assign mclk_s = mclk_meta_q[1];
  assign sync_s = sync_meta_q[1];
  assign rxd_s = rxd_meta_q[1];
  assign lin_s = lin_meta_q[1];
  assign rise_w = mclk_s && !mclk_prev_q;
  assign fall_w = !mclk_s && mclk_prev_q;

  // ---------------------------------------------------------------------------
  // Frame slot counter
  // ---------------------------------------------------------------------------
  logic active_q, lin_q, sync_hit_w;
  logic [SLOT_W-1:0] slot_q, tx_last_w, rx_last_w;

  assign sync_hit_w = fall_w && sync_s;
  assign tx_last_w = lin_q ? SLOT_LIN_LAST : SLOT_CMP_LAST;
  assign rx_last_w = lin_q ? SLOT_RX_LIN_LAST : SLOT_CMP_LAST;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_q <= 1'b0;
      lin_q <= 1'b0;
      slot_q <= '0;
    end else if (sync_hit_w) begin
      active_q <= 1'b1;
      lin_q <= !lin_s;
      slot_q <= SLOT_FIRST;
    end else if (fall_w && active_q && slot_q != SLOT_MAX) begin
      slot_q <= slot_q + SLOT_FIRST;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      frame_error_out <= 1'b0;
    end else begin
      frame_error_out <= sync_hit_w && active_q && slot_q != SLOT_FRAME;
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit shifter
  // ---------------------------------------------------------------------------
  logic [LIN_BITS-1:0] tx_sr_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_sr_q <= '0;
      tx_load_out <= 1'b0;
    end else begin
      tx_load_out <= sync_hit_w;
      if (sync_hit_w) begin
        tx_sr_q <= lin_s ? {tx_sample_in[CMP_BITS-1:0], 5'h00} : tx_sample_in[LIN_BITS-1:0];
      end else if (rise_w && active_q && slot_q >= SLOT_FIRST && slot_q <= tx_last_w) begin
        tx_sr_q <= {tx_sr_q[LIN_BITS-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      serial_tx_data_out <= 1'b0;
      serial_tx_data_oe_b_out <= 1'b1;
    end else if (rise_w && active_q && slot_q >= SLOT_FIRST && slot_q <= tx_last_w) begin
      serial_tx_data_out <= tx_sr_q[LIN_BITS-1];
      serial_tx_data_oe_b_out <= 1'b0;
    end else if (fall_w && slot_q == tx_last_w) begin
      serial_tx_data_oe_b_out <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Receive capture
  // ---------------------------------------------------------------------------
  logic [RX_W-1:0] rx_sr_q, rx_next_w;
  logic rx_cap_w;

  assign rx_cap_w = fall_w && active_q && !sync_s && slot_q >= SLOT_FIRST && slot_q <= rx_last_w;
  assign rx_next_w = {rx_sr_q[RX_W-2:0], rxd_s};

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_sr_q <= '0;
      rx_valid_out <= 1'b0;
      rx_sample_out <= '0;
      rx_gain_code_out <= '0;
      rx_gain_db_out <= GAIN_FIXED_DB;
    end else begin
      rx_valid_out <= rx_cap_w && slot_q == rx_last_w;
      if (rx_cap_w) begin
        rx_sr_q <= rx_next_w;
      end
      if (rx_cap_w && slot_q == rx_last_w) begin
        if (lin_q) begin
          rx_sample_out <= rx_next_w[RX_W-1:GAIN_BITS];
          rx_gain_code_out <= rx_next_w[GAIN_BITS-1:0];
          rx_gain_db_out <= GAIN_TOP_DB - GAIN_STEP_DB * $signed({3'h0, rx_next_w[GAIN_BITS-1:0]});
        end else begin
          rx_sample_out <= {5'h00, rx_next_w[CMP_BITS-1:0]};
          rx_gain_code_out <= '0;
          rx_gain_db_out <= GAIN_FIXED_DB;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Master clock loss detection
  // ---------------------------------------------------------------------------
  logic [IDLE_W-1:0] idle_q;
  logic idle_hit_w;

  assign idle_hit_w = idle_q == IDLE_W'(PD_TIMEOUT_CLKS - 1);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idle_q <= '0;
      power_down_out <= 1'b0;
    end else if (rise_w || fall_w) begin
      idle_q <= '0;
      power_down_out <= 1'b0;
    end else if (!idle_hit_w) begin
      idle_q <= idle_q + IDLE_W'(1);
    end else if (serial_tx_data_oe_b_out) begin
      power_down_out <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_launch;
    rise_w && active_q && slot_q == SLOT_FIRST;
  endsequence

  sequence s_final_fall;
    fall_w && slot_q == tx_last_w && !serial_tx_data_oe_b_out;
  endsequence

  a_sync_slot_one:
    assert property (sync_hit_w |=> slot_q == SLOT_FIRST && active_q)
      else $error("Slot counter did not restart at sync.");
  a_tx_msb_launch:
    assert property (s_launch |=> !serial_tx_data_oe_b_out && serial_tx_data_out == $past(tx_sr_q[LIN_BITS-1]))
      else $error("First transmit bit not driven at slot one.");
  a_tx_edge_only:
    assert property ($changed(serial_tx_data_out) |-> $past(rise_w))
      else $error("Transmit data changed off a rising edge.");
  a_tx_release:
    assert property (s_final_fall |=> serial_tx_data_oe_b_out)
      else $error("Transmit line not released after last slot.");
  a_tx_drive_start:
    assert property ($fell(serial_tx_data_oe_b_out) |-> $past(rise_w && slot_q == SLOT_FIRST))
      else $error("Transmit line driven outside slot one.");
  a_rx_word_len:
    assert property (rx_valid_out |-> $past(fall_w && slot_q == (lin_q ? SLOT_RX_LIN_LAST : SLOT_CMP_LAST)))
      else $error("Receive word length wrong for mode.");
  a_gain_linear:
    assert property (rx_valid_out && lin_q |->
      rx_gain_db_out == GAIN_TOP_DB - GAIN_STEP_DB * $signed({3'h0, rx_gain_code_out}))
      else $error("Linear gain mapping wrong.");
  a_gain_companded:
    assert property (rx_valid_out && !lin_q |-> rx_gain_db_out == GAIN_FIXED_DB && rx_gain_code_out == 3'h0)
      else $error("Companded gain not fixed at zero.");
  a_pd_quiet:
    assert property (power_down_out |-> serial_tx_data_oe_b_out)
      else $error("Transmit line driven in power-down.");
  a_pd_entry:
    assert property (idle_hit_w && !rise_w && !fall_w && serial_tx_data_oe_b_out |=> power_down_out)
      else $error("Power-down not entered after clock loss.");
  a_frame_check:
    assert property (sync_hit_w && active_q && slot_q != SLOT_FRAME |=> frame_error_out)
      else $error("Bad frame length not flagged.");

endmodule

// *** pcm_host_model.sv ***
// Host model that drives master clock, frame sync and receive data.
module pcm_host_model (
  input wire logic run_in,
  input wire logic [8:0] len_in,
  input wire logic [15:0] word_in,
  output logic mclk_out,
  output logic frame_sync_out,
  output logic serial_rx_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int c = 0;
  initial begin
    mclk_out = 1'b0;
    frame_sync_out = 1'b0;
    serial_rx_data_out = 1'b0;
    #3;
    forever begin
      wait (run_in);
      mclk_out = 1'b1;
      frame_sync_out = (c == 0);
      serial_rx_data_out = (c >= 1 && c <= 16) ? word_in[16-c] : ~serial_rx_data_out;
      #60 mclk_out = 1'b0;
      #60 c = (c + 1 >= len_in) ? 0 : c + 1;
    end
  end
endmodule

// *** tb_pcm_serial_frame_port.sv ***
// Self-checking bench for the serial PCM frame port.
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_pcm_serial_frame_port;
  timeunit 1ns;
  timeprecision 100ps;
  import pcm_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, run = 1'b0, lin = 1'b0, mclk, sync, rxd;
  logic [8:0] len = 9'h100;
  logic [15:0] word = 16'h0000;
  logic [12:0] tx_sample = 13'h0000;
  logic tx_load, txd, oe_b, rx_valid, ferr, pd;
  logic [12:0] rx_sample;
  logic [2:0] gain_code;
  logic signed [5:0] gain_db;
  int n_errors = 0, num_checks = 0, n_tx = 0, k = 0, n_ferr = 0, cyc = 0, nb;
  bit tx_q[$];
  bit eb;
  always #5 clk = ~clk;
  pcm_host_model i_pcm_host_model (.run_in(run), .len_in(len), .word_in(word), .mclk_out(mclk),
    .frame_sync_out(sync), .serial_rx_data_out(rxd));
  pcm_serial_frame_port i_pcm_serial_frame_port (.clk_in(clk), .rst_b_in(rst_b), .mclk_in(mclk),
    .frame_sync_in(sync), .serial_rx_data_in(rxd), .linear_select_in(lin), .tx_sample_in(tx_sample),
    .tx_load_out(tx_load), .serial_tx_data_out(txd), .serial_tx_data_oe_b_out(oe_b),
    .rx_sample_out(rx_sample), .rx_gain_code_out(gain_code), .rx_gain_db_out(gain_db),
    .rx_valid_out(rx_valid), .frame_error_out(ferr), .power_down_out(pd));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (ferr === 1'b1) n_ferr++;
    if (tx_load === 1'b1) begin
      for (int b = (lin ? 7 : 12); b >= 0; b--) tx_q.push_back(tx_sample[b]);
      tx_sample <= #1 13'($urandom);
    end
    if (cyc == 60000) begin
      n_errors++;
      report_and_stop();
    end
  end
  always @(negedge mclk) begin
    k = sync ? 0 : k + 1;
    if (oe_b === 1'b0) begin
      n_tx++;
      eb = (tx_q.size() > 0) ? tx_q.pop_front() : ~txd;
      `CHK("tx_slot", n_tx, k)
      `CHK("tx_bit", eb, txd)
    end
  end
  initial begin
    void'($urandom(74136));
    step(10);
    rst_b = 1'b1;
    `CHK("oe_b_reset", 1, oe_b)
    for (int i = 0; i < 12; i++) begin
      lin = (i == 3 || i == 9);
      word = {13'($urandom), 3'(i)};
      len = (i == 10) ? 9'h0c8 : 9'h100;
      if (i == 0) run = 1'b1;
      if (i == 8) begin
        for (int n = 0; n < 4000 && tx_load !== 1'b1; n++) step(1);
        step(60);
        run = 1'b0;
        step(230);
        `CHK("pd_hold", 0, pd)
        `CHK("pd_busy_oe_b", 0, oe_b)
        run = 1'b1;
      end
      for (int n = 0; n < 4000 && rx_valid !== 1'b1; n++) step(1);
      `CHK("rx_valid", 1, rx_valid)
      nb = lin ? 8 : 13;
      `CHK("rx_sample", lin ? {5'h00, word[15:8]} : word[15:3], rx_sample)
      `CHK("rx_gain_code", lin ? 0 : word[2:0], gain_code)
      `CHK("rx_gain_db", lin ? 0 : 3 - 3 * int'(word[2:0]), gain_db)
      `CHK("tx_count", nb, n_tx)
      `CHK("tx_left", 0, tx_q.size())
      n_tx = 0;
      step(1);
      if (i == 6) begin
        run = 1'b0;
        step(230);
        `CHK("pd_on", 1, pd)
        `CHK("pd_oe_b", 1, oe_b)
        run = 1'b1;
        step(30);
        `CHK("pd_off", 0, pd)
      end
      $display("frame %0d done", i);
    end
    `CHK("frame_errors", 1, n_ferr)
    report_and_stop();
  end
endmodule
